// ### verilog/uvoc_consts.svh
/*
  Command codes, field positions, reset values and fixed codes for the
  undervoltage and overcurrent limit command logic.
  Assumes it is included by bare name from the core and the monitor.
*/
`ifndef UVOC_CONSTS_SVH
`define UVOC_CONSTS_SVH

// Command codes
`define UVOC_CMD_UV_LIMIT 8'h44
`define UVOC_CMD_UV_RESP 8'h45
`define UVOC_CMD_OC_LIMIT 8'h46

// Linear word layout
`define UVOC_EXP_HI 15
`define UVOC_EXP_LO 11
`define UVOC_MANT_HI 10
`define UVOC_UV_EXP 5'h17
`define UVOC_OC_EXP 5'h1f
`define UVOC_OC_MANT_HI 6
`define UVOC_OC_PAD 4'h0

// Undervoltage limit values
`define UVOC_UV_MANT_RST 11'h130
`define UVOC_UV_MANT_ZERO 11'h000
`define UVOC_UV_MIN_PRODUCT 19'h0_00b0
`define UVOC_UV_NVM_LSB 4
`define UVOC_UV_NVM_PAD 4'h0

// Response byte layout
`define UVOC_RESP_SHUT_BIT 7
`define UVOC_RETRY_HI 5
`define UVOC_RETRY_LO 3
`define UVOC_RESP_RST 8'hbf
`define UVOC_RETRY_NONE 3'h0
`define UVOC_RETRY_ALWAYS 3'h7
`define UVOC_DELAY_CODE 3'h7
`define UVOC_BYTE_PAD 8'h00

`endif

// ### verilog/uvoc_pkg.sv
/*
  Types shared by the undervoltage and overcurrent limit command logic.
  Includes no other file; the constants header is used by the core and the monitor.
*/
`default_nettype none

package uvoc_pkg;

    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] data;
    } uvoc_wr_t;

    typedef struct packed {
        logic command_error;
        logic invalid_data;
        logic other_fault;
        logic vout_word_flag;
        logic undervoltage_fault_flag;
        logic turn_on_timeout_fault;
    } uvoc_status_t;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_SOFTSTART = 5'h02,
        ST_REGULATE = 5'h04,
        ST_HICCUP = 5'h08,
        ST_LATCHED = 5'h10
    } uvoc_state_t;

endpackage

`default_nettype wire

// ### verilog/uvoc_core.sv
/*
  Command logic for the output undervoltage fault limit, the undervoltage
  fault response and the overcurrent fault limit, with the undervoltage
  fault sequencer and a shadow copy of the saved defaults.
  Assumes the command decoder runs on clk_sys_i and hands over one write
  or read per strobe; comparator inputs are asynchronous and synchronised
  here; neighbouring warning limits and scale arrive on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

`include "uvoc_consts.svh"

// Behaviour
// - Bad undervoltage limit write kept out, flagged, alerted
// - Limit above 176/scale and below warning limit
// - Undervoltage check masked in start-up and off
// - Zero limit accepted and disables undervoltage fault
// - Saved undervoltage limit loses its four low bits
// - Undervoltage exponent fixed at minus nine
// - Undervoltage mantissa defaults to 304
// - Start-up timeout raises its own fault instead
// - Undervoltage fault sets status bits and alert
// - Response low bits read constant seven
// - Bit 7 selects ignore or shut down
// - Retry none latches output off until cleared
// - Retry always restarts through soft start forever
// - Other retry codes rejected with error flags
// - Only retry bit 5 saved, others rebuilt
// - Overcurrent limit below warning limit is flagged
// - Overcurrent exponent fixed, low mantissa bits writable
module uvoc_core #(
    parameter int RISE_W = 16,
    parameter logic [6:0] OC_MANT_RST = 7'h30
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Command write
    input wire logic cmd_wr_valid_i,
    input wire uvoc_pkg::uvoc_wr_t cmd_wr_i,
    // Command read
    input wire logic cmd_rd_valid_i,
    input wire logic [7:0] cmd_rd_code_i,
    output logic rd_valid_o,
    output logic rd_hit_o,
    output logic [15:0] rd_data_o,
    // Neighbouring limits and scale
    input wire logic [7:0] vout_scale_loop_i,
    input wire logic [10:0] uv_warn_mant_i,
    input wire logic [6:0] oc_warn_mant_i,
    // Fault management and saved defaults
    input wire logic store_all_i,
    input wire logic restore_all_i,
    input wire logic clear_faults_i,
    input wire logic alert_mask_i,
    // Converter control
    input wire logic conv_enable_i,
    input wire logic [RISE_W-1:0] soft_start_rise_time_i,
    input wire logic turn_on_timeout_i,
    input wire logic vout_below_uv_pin_i,
    input wire logic vout_reached_pin_i,
    // Status and converter outputs
    output uvoc_pkg::uvoc_status_t status_o,
    output logic smbalert_o,
    output logic power_stage_on_o,
    output logic uv_check_active_o,
    output logic [10:0] uv_threshold_o,
    output logic [6:0] oc_threshold_o
);
    import uvoc_pkg::*;

    localparam int CNT_W = RISE_W + 3;
    // Named copies so reset fields can be selected; a literal cannot be indexed
    localparam logic [7:0] RESP_RST = `UVOC_RESP_RST;
    localparam logic [10:0] UV_MANT_RST = `UVOC_UV_MANT_RST;

    function automatic logic uv_limit_ok(input logic [10:0] mant, input logic [7:0] scale,
                                         input logic [10:0] warn);
        logic [18:0] prod;
        prod = 19'(mant) * 19'(scale);
        if (mant == `UVOC_UV_MANT_ZERO) begin
            return 1'b1;
        end
        return (prod > `UVOC_UV_MIN_PRODUCT) && (mant < warn);
    endfunction

    function automatic logic retry_ok(input logic [2:0] code);
        return (code == `UVOC_RETRY_NONE) || (code == `UVOC_RETRY_ALWAYS);
    endfunction

    function automatic logic [CNT_W-1:0] hiccup_len(input logic [RISE_W-1:0] rise);
        return CNT_W'(`UVOC_DELAY_CODE) * CNT_W'(rise);
    endfunction

    // Live command registers
    logic [10:0] uv_mant;
    logic ignore_or_shutdown_select;
    logic [2:0] retry_setting;
    logic [6:0] oc_mant;
    // Saved default image
    logic [10:`UVOC_UV_NVM_LSB] nvm_uv_mant_hi;
    logic nvm_shut;
    logic nvm_retry_bit;
    logic [6:0] nvm_oc_mant;
    // Comparator synchronisers
    logic below_meta;
    logic below_sync;
    logic reached_meta;
    logic reached_sync;
    // Sequencer
    uvoc_state_t state;
    uvoc_state_t next_state;
    logic [CNT_W-1:0] hiccup_cnt;
    uvoc_status_t status;
    uvoc_status_t next_status;

    logic wr_uv;
    logic wr_resp;
    logic wr_oc;
    logic uv_reject;
    logic resp_reject;
    logic oc_reject;
    logic write_reject;
    logic uv_armed;
    logic uv_event;
    logic ton_event;
    logic [2:0] wr_retry;

    assign wr_uv = cmd_wr_valid_i && (cmd_wr_i.cmd == `UVOC_CMD_UV_LIMIT);
    assign wr_resp = cmd_wr_valid_i && (cmd_wr_i.cmd == `UVOC_CMD_UV_RESP);
    assign wr_oc = cmd_wr_valid_i && (cmd_wr_i.cmd == `UVOC_CMD_OC_LIMIT);
    assign wr_retry = cmd_wr_i.data[`UVOC_RETRY_HI:`UVOC_RETRY_LO];

    // Only the mantissa is judged; exponent bits of the word are ignored
    assign uv_reject = wr_uv && !uv_limit_ok(cmd_wr_i.data[`UVOC_MANT_HI:0],
                                             vout_scale_loop_i, uv_warn_mant_i);
    assign resp_reject = wr_resp && !retry_ok(wr_retry);
    assign oc_reject = wr_oc && (cmd_wr_i.data[`UVOC_OC_MANT_HI:0] < oc_warn_mant_i);
    assign write_reject = uv_reject || resp_reject || oc_reject;

    // A zero limit switches the whole undervoltage fault path off
    assign uv_armed = (uv_mant != `UVOC_UV_MANT_ZERO);
    // Only armed once the output has been seen at its target
    assign uv_event = (state == ST_REGULATE) && uv_armed && below_sync;
    assign ton_event = (state == ST_SOFTSTART) && turn_on_timeout_i && !reached_sync;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            below_meta <= 1'b0;
            below_sync <= 1'b0;
            reached_meta <= 1'b0;
            reached_sync <= 1'b0;
        end else begin
            below_meta <= vout_below_uv_pin_i;
            below_sync <= below_meta;
            reached_meta <= vout_reached_pin_i;
            reached_sync <= reached_meta;
        end
    end

    // Restore beats a write in the same cycle
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            uv_mant <= `UVOC_UV_MANT_RST;
        end else if (restore_all_i) begin
            uv_mant <= {nvm_uv_mant_hi, `UVOC_UV_NVM_PAD};
        end else if (wr_uv && !uv_reject) begin
            uv_mant <= cmd_wr_i.data[`UVOC_MANT_HI:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ignore_or_shutdown_select <= RESP_RST[`UVOC_RESP_SHUT_BIT];
            retry_setting <= RESP_RST[`UVOC_RETRY_HI:`UVOC_RETRY_LO];
        end else if (restore_all_i) begin
            ignore_or_shutdown_select <= nvm_shut;
            retry_setting <= {3{nvm_retry_bit}};
        end else if (wr_resp && !resp_reject) begin
            ignore_or_shutdown_select <= cmd_wr_i.data[`UVOC_RESP_SHUT_BIT];
            retry_setting <= wr_retry;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oc_mant <= OC_MANT_RST;
        end else if (restore_all_i) begin
            oc_mant <= nvm_oc_mant;
        end else if (wr_oc && !oc_reject) begin
            oc_mant <= cmd_wr_i.data[`UVOC_OC_MANT_HI:0];
        end
    end

    // The saved image starts out holding the power-on defaults
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nvm_uv_mant_hi <= UV_MANT_RST[10:`UVOC_UV_NVM_LSB];
            nvm_shut <= RESP_RST[`UVOC_RESP_SHUT_BIT];
            nvm_retry_bit <= RESP_RST[`UVOC_RETRY_HI];
            nvm_oc_mant <= OC_MANT_RST;
        end else if (store_all_i) begin
            nvm_uv_mant_hi <= uv_mant[10:`UVOC_UV_NVM_LSB];
            nvm_shut <= ignore_or_shutdown_select;
            nvm_retry_bit <= retry_setting[`UVOC_RETRY_HI - `UVOC_RETRY_LO];
            nvm_oc_mant <= oc_mant;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (conv_enable_i) begin
                    next_state = ST_SOFTSTART;
                end
            end
            ST_SOFTSTART: begin
                if (!conv_enable_i) begin
                    next_state = ST_OFF;
                end else if (ton_event) begin
                    next_state = ST_LATCHED;
                end else if (reached_sync) begin
                    next_state = ST_REGULATE;
                end
            end
            ST_REGULATE: begin
                if (!conv_enable_i) begin
                    next_state = ST_OFF;
                end else if (uv_event && ignore_or_shutdown_select) begin
                    if (retry_setting == `UVOC_RETRY_ALWAYS) begin
                        next_state = ST_HICCUP;
                    end else begin
                        next_state = ST_LATCHED;
                    end
                end
            end
            ST_HICCUP: begin
                if (!conv_enable_i) begin
                    next_state = ST_OFF;
                end else if (hiccup_cnt <= CNT_W'(1)) begin
                    next_state = ST_SOFTSTART;
                end
            end
            ST_LATCHED: begin
                if (!conv_enable_i || clear_faults_i) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Rise time is sampled on entry, so a change mid-delay waits for the next delay
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hiccup_cnt <= '0;
        end else if (state != ST_HICCUP) begin
            hiccup_cnt <= hiccup_len(soft_start_rise_time_i);
        end else if (hiccup_cnt != '0) begin
            hiccup_cnt <= hiccup_cnt - CNT_W'(1);
        end
    end

    // A set arriving with the clear survives it
    always_comb begin
        next_status = clear_faults_i ? '0 : status;
        if (write_reject) begin
            next_status.command_error = 1'b1;
            next_status.invalid_data = 1'b1;
        end
        if (uv_event) begin
            next_status.other_fault = 1'b1;
            next_status.vout_word_flag = 1'b1;
            next_status.undervoltage_fault_flag = 1'b1;
        end
        if (ton_event) begin
            next_status.vout_word_flag = 1'b1;
            next_status.turn_on_timeout_fault = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status <= '0;
            smbalert_o <= 1'b0;
        end else begin
            status <= next_status;
            smbalert_o <= (|next_status) && !alert_mask_i;
        end
    end

    assign status_o = status;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_stage_on_o <= 1'b0;
            uv_check_active_o <= 1'b0;
        end else begin
            power_stage_on_o <= (next_state == ST_SOFTSTART) || (next_state == ST_REGULATE);
            uv_check_active_o <= (next_state == ST_REGULATE) && uv_armed;
        end
    end

    // Threshold copies follow the live registers by one cycle
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            uv_threshold_o <= `UVOC_UV_MANT_RST;
            oc_threshold_o <= OC_MANT_RST;
        end else begin
            uv_threshold_o <= uv_mant;
            oc_threshold_o <= oc_mant;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_hit_o <= 1'b0;
            rd_data_o <= '0;
        end else begin
            rd_valid_o <= cmd_rd_valid_i;
            if (cmd_rd_valid_i) begin
                rd_hit_o <= 1'b1;
                unique case (cmd_rd_code_i)
                    `UVOC_CMD_UV_LIMIT: begin
                        rd_data_o <= {`UVOC_UV_EXP, uv_mant};
                    end
                    `UVOC_CMD_UV_RESP: begin
                        rd_data_o <= {`UVOC_BYTE_PAD, ignore_or_shutdown_select, 1'b0,
                                      retry_setting, `UVOC_DELAY_CODE};
                    end
                    `UVOC_CMD_OC_LIMIT: begin
                        rd_data_o <= {`UVOC_OC_EXP, `UVOC_OC_PAD, oc_mant};
                    end
                    default: begin
                        rd_hit_o <= 1'b0;
                        rd_data_o <= '0;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ### test/uvoc_monitor.sv
/* Concurrent checks on the undervoltage and overcurrent command block.
   Assumes it is bound to uvoc_core and sees only that module's ports. */
`timescale 1ns/1ns
`default_nettype none
`include "uvoc_consts.svh"
module uvoc_monitor (
    // Clock, reset and requests
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic cmd_wr_valid_i,
    input wire uvoc_pkg::uvoc_wr_t cmd_wr_i,
    input wire logic cmd_rd_valid_i,
    input wire logic [7:0] cmd_rd_code_i,
    input wire logic [10:0] uv_warn_mant_i,
    input wire logic [6:0] oc_warn_mant_i,
    input wire logic clear_faults_i,
    input wire logic alert_mask_i,
    // Responses
    input wire logic rd_valid_o,
    input wire logic [15:0] rd_data_o,
    input wire uvoc_pkg::uvoc_status_t status_o,
    input wire logic smbalert_o,
    input wire logic power_stage_on_o,
    input wire logic uv_check_active_o
);
    import uvoc_pkg::*;
    default clocking dcb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_rd(c);
        cmd_rd_valid_i && cmd_rd_code_i == c;
    endsequence
    sequence s_wr(c, ok);
        cmd_wr_valid_i && cmd_wr_i.cmd == c && ok;
    endsequence
    sequence s_rej;
        status_o.command_error && status_o.invalid_data;
    endsequence
    property p_uv_exp; s_rd(`UVOC_CMD_UV_LIMIT) |=> rd_valid_o && rd_data_o[15:11] == `UVOC_UV_EXP; endproperty
    a_uv_exp: assert property (p_uv_exp) else $error("limit exponent wrong");
    property p_resp_rd; s_rd(`UVOC_CMD_UV_RESP) |=> rd_data_o[15:6] == 10'h000 && rd_data_o[2:0] == 3'h7; endproperty
    a_resp_rd: assert property (p_resp_rd) else $error("response fixed bits wrong");
    property p_uv_rej; s_wr(`UVOC_CMD_UV_LIMIT, cmd_wr_i.data[10:0] != 0
        && cmd_wr_i.data[10:0] >= uv_warn_mant_i) |=> s_rej; endproperty
    a_uv_rej: assert property (p_uv_rej) else $error("bad limit not flagged");
    property p_resp_rej; s_wr(`UVOC_CMD_UV_RESP, !(cmd_wr_i.data[5:3] inside {3'h0, 3'h7}))
        |=> s_rej; endproperty
    a_resp_rej: assert property (p_resp_rej) else $error("bad retry not flagged");
    property p_oc_rej; s_wr(`UVOC_CMD_OC_LIMIT, cmd_wr_i.data[6:0] < oc_warn_mant_i) |=> s_rej; endproperty
    a_oc_rej: assert property (p_oc_rej) else $error("low current limit not flagged");
    property p_sticky; status_o.invalid_data && !clear_faults_i |=> status_o.invalid_data; endproperty
    a_sticky: assert property (p_sticky) else $error("error flag lost");
    property p_alert; smbalert_o == ((|status_o) && !$past(alert_mask_i)); endproperty
    a_alert: assert property (p_alert) else $error("alert disagrees with flags");
    property p_uv_mask; !power_stage_on_o |-> !uv_check_active_o; endproperty
    a_uv_mask: assert property (p_uv_mask) else $error("check active while off");
    property p_uv_flags; $rose(status_o.undervoltage_fault_flag) |-> status_o.other_fault && status_o.vout_word_flag;
    endproperty
    a_uv_flags: assert property (p_uv_flags) else $error("fault summary flags missing");
endmodule
bind uvoc_core uvoc_monitor u_mon (.clk_sys_i, .arst_n_i, .cmd_wr_valid_i, .cmd_wr_i, .cmd_rd_valid_i,
    .cmd_rd_code_i, .uv_warn_mant_i, .oc_warn_mant_i, .clear_faults_i, .alert_mask_i, .rd_valid_o,
    .rd_data_o, .status_o, .smbalert_o, .power_stage_on_o, .uv_check_active_o);
`default_nettype wire

// ### test/uvoc_host.sv
/* Host command model: issues one write or one read at a time.
   Assumes the device takes a request on the edge where its strobe is high. */
`timescale 1ns/1ns
`default_nettype none
module uvoc_host (
    // Clock
    input wire logic clk_sys_i,
    // Requests toward the device
    output logic cmd_wr_valid_o,
    output uvoc_pkg::uvoc_wr_t cmd_wr_o,
    output logic cmd_rd_valid_o,
    output logic [7:0] cmd_rd_code_o,
    // Read answer
    input wire logic rd_valid_i,
    input wire logic rd_hit_i,
    input wire logic [15:0] rd_data_i
);
    import uvoc_pkg::*;
    initial begin
        cmd_wr_valid_o = 1'b0;
        cmd_wr_o = '0;
        cmd_rd_valid_o = 1'b0;
        cmd_rd_code_o = 8'h00;
    end
    // Payloads are inverted once released, so stale data never looks valid
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_sys_i);
        cmd_wr_valid_o <= 1'b1;
        cmd_wr_o <= {c, d};
        @(posedge clk_sys_i);
        cmd_wr_valid_o <= 1'b0;
        cmd_wr_o <= ~{c, d};
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic [1:0] ok);
        @(posedge clk_sys_i);
        cmd_rd_valid_o <= 1'b1;
        cmd_rd_code_o <= c;
        @(posedge clk_sys_i);
        cmd_rd_valid_o <= 1'b0;
        cmd_rd_code_o <= ~c;
        // The answer stands for the one cycle after the taking edge
        #1;
        d = rd_data_i;
        ok = {rd_valid_i, rd_hit_i};
    endtask
endmodule
`default_nettype wire

// ### test/tb.sv
/* Self-checking bench: the host model issues commands while integer
   registers here predict the command reads and a flag register the status; power checks give their level directly.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import uvoc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wv, rv, rdv, hit, pwr, act, alert;
    logic store = 1'b0, rest = 1'b0, clr = 1'b0, mask = 1'b0;
    logic en = 1'b0, ton = 1'b0, below = 1'b0, reach = 1'b0;
    logic [7:0] rc;
    logic [7:0] scale = 8'h01;
    logic [10:0] uvw = 11'h200;
    logic [6:0] ocw = 7'h20;
    logic [15:0] rise = 16'h0002;
    logic [15:0] rdd;
    logic [5:0] fl = 6'h00;
    uvoc_wr_t w;
    uvoc_status_t st;
    integer seed = 32'h8ddc;
    int miscompares = 0, checks_done = 0, n;
    // Model registers and the saved image
    int uv = 'h130, rsp = 'hbf, oc = 'h30, su, sr, so;
    int uvq[$] = '{176, 177, 'h1ff, 'h200, 0, 'h7ff, 'h130};
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    uvoc_core #(.RISE_W(16), .OC_MANT_RST(7'h30)) DUT (.clk_sys_i, .arst_n_i, .cmd_wr_valid_i(wv), .cmd_wr_i(w),
        .cmd_rd_valid_i(rv), .cmd_rd_code_i(rc), .rd_valid_o(rdv), .rd_hit_o(hit), .rd_data_o(rdd),
        .vout_scale_loop_i(scale), .uv_warn_mant_i(uvw), .oc_warn_mant_i(ocw), .store_all_i(store),
        .restore_all_i(rest), .clear_faults_i(clr), .alert_mask_i(mask), .conv_enable_i(en),
        .soft_start_rise_time_i(rise), .turn_on_timeout_i(ton), .vout_below_uv_pin_i(below),
        .vout_reached_pin_i(reach), .status_o(st), .smbalert_o(alert), .power_stage_on_o(pwr),
        .uv_check_active_o(act), .uv_threshold_o(), .oc_threshold_o());
    uvoc_host HST (.clk_sys_i, .cmd_wr_valid_o(wv), .cmd_wr_o(w), .cmd_rd_valid_o(rv), .cmd_rd_code_o(rc),
        .rd_valid_i(rdv), .rd_hit_i(hit), .rd_data_i(rdd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys_i) {store, rest, clr} <= 3'(1 << k);
        @(posedge clk_sys_i) {store, rest, clr} <= 3'b000;
    endtask
    task automatic clear();
        repeat (4) @(posedge clk_sys_i);
        pulse(0);
        fl = 6'h00;
        #1;
        chk(st, 0, "cleared");
    endtask
    // Every read also proves the flags held since the write that set them
    task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] d;
        logic [1:0] ok;
        HST.rd(c, d, ok);
        chk(ok, (c inside {8'h44, 8'h45, 8'h46}) ? 2'b11 : 2'b10, "hit");
        chk(d, exp, "read");
        chk(st, fl, "status");
        chk(alert, fl != 0, "alert");
        if (fl != 0) clear();
    endtask
    task automatic wuv(input int m);
        HST.wr(8'h44, {5'($random(seed)), 11'(m)});
        if (m == 0 || (m * scale > 176 && m < uvw)) uv = m;
        else fl = 6'b110000;
        rdchk(8'h44, {5'h17, 11'(uv)});
    endtask
    task automatic wrs(input int s, input int r);
        HST.wr(8'h45, {8'($random(seed)), 1'(s), 1'($random(seed)), 3'(r), 3'($random(seed))});
        if (r == 0 || r == 7) rsp = s * 128 + r * 8 + 7;
        else fl = 6'b110000;
        rdchk(8'h45, 16'(rsp));
    endtask
    task automatic woc(input int m);
        HST.wr(8'h46, {9'($random(seed)), 7'(m)});
        if (m >= ocw) oc = m;
        else fl = 6'b110000;
        rdchk(8'h46, {9'h1f0, 7'(oc)});
    endtask
    task automatic wpwr(input logic lv, input int lim, output int cnt);
        cnt = 0;
        #1;
        while (pwr !== lv && cnt < lim) begin
            @(posedge clk_sys_i);
            #1;
            cnt++;
        end
        chk(pwr, lv, "power");
    endtask
    task automatic test_done();
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        rdchk(8'h44, 16'hb930);
        rdchk(8'h45, 16'h00bf);
        rdchk(8'h46, 16'hf830);
        rdchk(8'h47, 16'h0000);
        foreach (uvq[i]) wuv(uvq[i]);
        @(posedge clk_sys_i) scale <= 8'h02;
        wuv(88);
        wuv(89);
        repeat (6) wuv($random(seed) & 'h3ff);
        for (int r = 0; r < 8; r++) wrs(r & 1, r);
        woc(ocw - 1);
        woc(ocw);
        repeat (4) woc($random(seed) & 'h7f);
        wuv('h15b);
        wrs(0, 0);
        pulse(2);
        su = uv & 'h7f0;
        sr = rsp;
        so = oc;
        wuv('h160);
        wrs(1, 7);
        woc('h7f);
        pulse(1);
        uv = su;
        rsp = sr;
        oc = so;
        rdchk(8'h44, {5'h17, 11'(uv)});
        rdchk(8'h45, 16'(rsp));
        rdchk(8'h46, {9'h1f0, 7'(oc)});
        @(posedge clk_sys_i) below <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk(st, 0, "masked while off");
        @(posedge clk_sys_i) en <= 1'b1;
        wpwr(1, 5, n);
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk(st, 0, "masked in start-up");
        @(posedge clk_sys_i);
        mask <= 1'b1;
        reach <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk(st, 6'b001110, "fault flags");
        chk(alert, 0, "masked alert");
        chk(pwr, 1, "ignore keeps power");
        @(posedge clk_sys_i) mask <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(alert, 1, "alert");
        @(posedge clk_sys_i) below <= 1'b0;
        clear();
        wrs(1, 7);
        @(posedge clk_sys_i) below <= 1'b1;
        wpwr(0, 8, n);
        repeat (2) begin
            wpwr(1, 40, n);
            chk(n >= 14 && n <= 17, 1, "restart delay");
            wpwr(0, 8, n);
        end
        chk(st, 6'b001110, "fault flags");
        @(posedge clk_sys_i) below <= 1'b0;
        clear();
        wrs(1, 0);
        // Let the last restart finish so the fault is seen in regulation
        wpwr(1, 40, n);
        @(posedge clk_sys_i) below <= 1'b1;
        wpwr(0, 8, n);
        @(posedge clk_sys_i) below <= 1'b0;
        repeat (30) @(posedge clk_sys_i);
        #1;
        chk(pwr, 0, "latched off");
        clear();
        wpwr(1, 10, n);
        wuv(0);
        @(posedge clk_sys_i) below <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk(st, 0, "zero limit");
        chk(act, 0, "zero limit check");
        @(posedge clk_sys_i) below <= 1'b0;
        wuv('h150);
        chk(act, 1, "check active");
        @(posedge clk_sys_i) en <= 1'b0;
        reach <= 1'b0;
        wpwr(0, 5, n);
        @(posedge clk_sys_i) en <= 1'b1;
        wpwr(1, 5, n);
        @(posedge clk_sys_i) ton <= 1'b1;
        @(posedge clk_sys_i) ton <= 1'b0;
        wpwr(0, 5, n);
        chk(st, 6'b000101, "turn-on timeout");
        clear();
        test_done();
    end
endmodule
`default_nettype wire
